// *** rtl/gec_pkg.sv ***
// Package for the global error collector: offsets, resets, carriers
package gec_pkg;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int GEC_NUM_CLASSES = 3;
  localparam int GEC_NUM_PORTS = 4;
  localparam int GEC_NUM_CLUSTERS = GEC_NUM_PORTS + 3;
  localparam int GEC_ADDR_W = 8;
  localparam int GEC_SYNC_STAGES = 3;

  // Class indices in every per-class array
  localparam int GEC_CLS_CORR = 0;
  localparam int GEC_CLS_NONFATAL = 1;
  localparam int GEC_CLS_FATAL = 2;

  // Cluster bit positions inside every status and log register
  localparam int GEC_BIT_MEMCTL = 0;
  localparam int GEC_BIT_SYSAGENT = 1;
  localparam int GEC_BIT_PORT0 = 2;
  localparam int GEC_BIT_COLLECTOR = GEC_BIT_PORT0 + GEC_NUM_PORTS;

  // ==========================================================
  // Register byte offsets; per-class groups step by one word
  // ==========================================================
  localparam logic [7:0] GEC_OFF_STATUS = 8'h00;
  localparam logic [7:0] GEC_OFF_GMASK = 8'h10;
  localparam logic [7:0] GEC_OFF_FIRST = 8'h20;
  localparam logic [7:0] GEC_OFF_NEXT = 8'h30;
  localparam logic [7:0] GEC_OFF_STAMP = 8'h40;
  localparam logic [7:0] GEC_OFF_SEV_STATUS = 8'h50;
  localparam logic [7:0] GEC_OFF_SEV_MASK = 8'h54;
  localparam logic [7:0] GEC_OFF_EVT_MAP = 8'h58;
  localparam logic [7:0] GEC_OFF_PIN_EN = 8'h5c;
  localparam logic [7:0] GEC_OFF_SYSERR_MAP = 8'h60;
  localparam logic [7:0] GEC_OFF_TIMER = 8'h64;

  // ==========================================================
  // Reset values
  // ==========================================================
  // Map bit 1 selects NMI, 0 selects SMI: corr SMI, others NMI
  localparam logic [2:0] GEC_RST_EVT_MAP = 3'h6;
  localparam logic [2:0] GEC_RST_SEV_MASK = 3'h0;
  localparam logic [2:0] GEC_RST_PIN_EN = 3'h0;
  localparam logic GEC_RST_SYSERR_MAP = 1'b1;
  localparam logic [GEC_NUM_CLUSTERS-1:0] GEC_RST_GMASK = '0;
  localparam logic [GEC_SYNC_STAGES-1:0] GEC_RST_SYNC_HIGH = '1;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef logic [GEC_NUM_CLUSTERS-1:0] gec_vec_t;

  // Reports from the local clusters, one pulse vector per class
  typedef struct packed {
    gec_vec_t fatal;
    gec_vec_t nonfatal;
    gec_vec_t correctable;
  } gec_report_s;

  // Events toward the processor, one-cycle pulses
  typedef struct packed {
    logic smi;
    logic nmi;
  } gec_event_s;

  // Active-low severity pins toward the management controller
  typedef struct packed {
    logic fatal_error_pin_n;
    logic nonfatal_error_pin_n;
    logic correctable_error_pin_n;
  } gec_pins_s;

endpackage : gec_pkg

// *** rtl/gec_global_error_collector.sv ***
// Global error collector: status, first/next logs, events and pins
//
// Summary of operation
// - Fatal, non-fatal and correctable status registers, a bit per cluster.
// - A cluster report sets its bit in the status register of its class.
// - Status bits clear only by writing one; zero leaves them alone.
// - A per-error mask stops later reports setting the status bit.
// - Global error mask is non-sticky; every reset clears it.
// - First and next logs per class, one bit per cluster, write-one-clear.
// - Time stamp is captured when a class records its first error.
// - A first log holds unchanged until software clears its bits or core power is lost.
// - Severity event bit is the OR of unmasked status of that class.
// - Each severity event bit has a mask that forces it to zero.
// - Rising severity event raises SMI or NMI as the map selects.
// - Enabled severity pin drives low while an error of it is logged.
// - Map resets to SMI for correctable, NMI for the others.
// - Severity event mask is non-sticky and cleared by a hard reset.
// - Instability error input is routed to NMI or SMI.
// - First error sets the first log, later errors set the next log.
// - First and next logging events raise no system event of their own; only a rising severity event bit raises one.
// - Logs stay valid until first log cleared or power is lost.
// - An error already in the first log is not put in next log.
// - Simultaneous errors of one class log two: first and next.
// - Status and logs change in one edge, reads see whole sets.
// - Status clears only at power-on; logs also clear on core power loss and survive platform reset.
// - Status sets on new reports; after clears the OR is reevaluated.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gec_global_error_collector
  import gec_pkg::*;
#(
  parameter int TS_WIDTH = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cluster reports and instability error, on pclk
  input wire gec_report_s err_report,
  input wire logic system_instability_error,
  // Board-level pins, asynchronous
  input wire logic platform_reset_out_n,
  input wire logic core_power_good_in,
  // Outputs
  output gec_event_s cpu_event,
  output gec_pins_s error_pins
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Stamp and time base each fit one bus word
  if (TS_WIDTH < 1 || TS_WIDTH > 32)
  begin : g_bad_ts
    $error("TS_WIDTH must lie between 1 and 32");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  // Class index of a per-class address group, or 3 when not in group
  function automatic logic [1:0] class_of(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d[7:4] == 4'h0 && d[1:0] == 2'b00 && d[3:2] != 2'b11)
      class_of = d[3:2];
    else
      class_of = 2'b11;
  endfunction : class_of

  // Lowest set bit of a cluster vector
  function automatic gec_vec_t lowest_bit(input gec_vec_t v);
    lowest_bit = v & (~v + gec_vec_t'(1));
  endfunction : lowest_bit

  // ==========================================================
  // Pin synchronisers: three stages, change once last two agree
  // ==========================================================
  logic [GEC_SYNC_STAGES-1:0] plat_sync;
  logic [GEC_SYNC_STAGES-1:0] pgood_sync;
  logic plat_rst_n;
  logic pgood;

  // Reset high: pins read as released, no false reset after power-on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      plat_sync <= GEC_RST_SYNC_HIGH;
      pgood_sync <= GEC_RST_SYNC_HIGH;
    end
    else
    begin
      plat_sync <= {plat_sync[1:0], platform_reset_out_n};
      pgood_sync <= {pgood_sync[1:0], core_power_good_in};
    end
  end

  // Filtered levels, updated only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      plat_rst_n <= 1'b1;
      pgood <= 1'b1;
    end
    else
    begin
      if (plat_sync[1] == plat_sync[2])
        plat_rst_n <= plat_sync[2];
      if (pgood_sync[1] == pgood_sync[2])
        pgood <= pgood_sync[2];
    end
  end

  // ==========================================================
  // APB decode
  // ==========================================================
  // Register map, byte offsets; class k is 0 corr, 1 nonfatal, 2 fatal
  //   0x00 + 4k  status, write one to clear
  //   0x10 + 4k  global error mask, read/write
  //   0x20 + 4k  first error log, write one to clear
  //   0x30 + 4k  next error log, write one to clear
  //   0x40 + 4k  first error time stamp, read only
  //   0x50       severity event status, read only
  //   0x54       severity event mask
  //   0x58       severity to event map, one selects NMI
  //   0x5c       severity pin enable
  //   0x60       instability event map, one selects NMI
  //   0x64       free-running time base, read only
  // Word 0xc of each per-class group and all else answer with an error
  logic setup_ph;
  logic wr_acc;
  logic [1:0] wcls_status;
  logic [1:0] wcls_gmask;
  logic [1:0] wcls_first;
  logic [1:0] wcls_next;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign wcls_status = class_of(paddr, GEC_OFF_STATUS);
  assign wcls_gmask = class_of(paddr, GEC_OFF_GMASK);
  assign wcls_first = class_of(paddr, GEC_OFF_FIRST);
  assign wcls_next = class_of(paddr, GEC_OFF_NEXT);
  // No wait state: data is registered in setup, answered in access
  assign pready = psel & penable;

  // ==========================================================
  // Per-class state
  // ==========================================================
  gec_vec_t report [GEC_NUM_CLASSES];
  gec_vec_t status [GEC_NUM_CLASSES];
  gec_vec_t gmask [GEC_NUM_CLASSES];
  gec_vec_t first_error_log [GEC_NUM_CLASSES];
  gec_vec_t next_error_log [GEC_NUM_CLASSES];
  logic [TS_WIDTH-1:0] stamp [GEC_NUM_CLASSES];
  logic [TS_WIDTH-1:0] timer;
  logic [2:0] sev_mask;
  logic [2:0] evt_map;
  logic [2:0] pin_en;
  logic syserr_map;
  logic [2:0] sev_status;
  logic [2:0] next_sev_status;

  // Reports unpacked per class so one loop serves all three
  assign report[GEC_CLS_CORR] = err_report.correctable;
  assign report[GEC_CLS_NONFATAL] = err_report.nonfatal;
  assign report[GEC_CLS_FATAL] = err_report.fatal;

  // Free-running time base for the first-error stamps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer <= '0;
    else
      timer <= timer + TS_WIDTH'(1);
  end

  // Non-sticky masks: any reset clears them; event controls clear on presetn only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < GEC_NUM_CLASSES; c++)
        gmask[c] <= GEC_RST_GMASK;
      sev_mask <= GEC_RST_SEV_MASK;
      evt_map <= GEC_RST_EVT_MAP;
      pin_en <= GEC_RST_PIN_EN;
      syserr_map <= GEC_RST_SYSERR_MAP;
    end
    else if (!plat_rst_n)
    begin
      for (int c = 0; c < GEC_NUM_CLASSES; c++)
        gmask[c] <= GEC_RST_GMASK;
      sev_mask <= GEC_RST_SEV_MASK;
    end
    else if (wr_acc)
    begin
      if (wcls_gmask != 2'b11)
        gmask[wcls_gmask] <= pwdata[GEC_NUM_CLUSTERS-1:0];
      if (paddr == GEC_OFF_SEV_MASK)
        sev_mask <= pwdata[2:0];
      if (paddr == GEC_OFF_EVT_MAP)
        evt_map <= pwdata[2:0];
      if (paddr == GEC_OFF_PIN_EN)
        pin_en <= pwdata[2:0];
      if (paddr == GEC_OFF_SYSERR_MAP)
        syserr_map <= pwdata[0];
    end
  end

  // Status and logs: all classes move on the same edge
  // A report meeting a write-one clear in one cycle keeps its bit set,
  // so an error raised while software clears is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < GEC_NUM_CLASSES; c++)
      begin
        status[c] <= '0;
        first_error_log[c] <= '0;
        next_error_log[c] <= '0;
        stamp[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < GEC_NUM_CLASSES; c++)
      begin
        gec_vec_t hit;
        gec_vec_t clr_s;
        gec_vec_t clr_f;
        gec_vec_t clr_n;
        gec_vec_t kept_f;
        gec_vec_t kept_n;
        gec_vec_t pick;
        hit = report[c] & ~gmask[c];
        clr_s = (wr_acc && wcls_status == c[1:0]) ?
                pwdata[GEC_NUM_CLUSTERS-1:0] : '0;
        clr_f = (wr_acc && wcls_first == c[1:0]) ?
                pwdata[GEC_NUM_CLUSTERS-1:0] : '0;
        clr_n = (wr_acc && wcls_next == c[1:0]) ?
                pwdata[GEC_NUM_CLUSTERS-1:0] : '0;
        // Set wins over a clear arriving in the same cycle
        status[c] <= (status[c] & ~clr_s) | hit;
        kept_f = first_error_log[c] & ~clr_f;
        kept_n = next_error_log[c] & ~clr_n;
        // Next log only lives while a first error is held
        if (kept_f == '0 && first_error_log[c] != '0)
          kept_n = '0;
        // Logs are lost only with core power; platform reset keeps them
        if (!pgood)
        begin
          kept_f = '0;
          kept_n = '0;
        end
        if (kept_f == '0 && hit != '0)
        begin
          // New first error: one to first log, one more to next log
          pick = lowest_bit(hit);
          first_error_log[c] <= pick;
          next_error_log[c] <= kept_n | lowest_bit(hit & ~pick);
          stamp[c] <= timer;
        end
        else
        begin
          first_error_log[c] <= kept_f;
          next_error_log[c] <= kept_n | (hit & ~kept_f);
        end
      end
    end
  end

  // ==========================================================
  // Severity events, processor events and pins
  // ==========================================================
  // Unmasked OR of each class; re-evaluated every cycle after clears
  always_comb
  begin
    for (int c = 0; c < GEC_NUM_CLASSES; c++)
      next_sev_status[c] = (|status[c]) & ~sev_mask[c];
  end

  // Rising edges raise one-cycle events; pins follow held first logs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sev_status <= '0;
      cpu_event <= '0;
      error_pins <= '1;
    end
    else
    begin
      logic [2:0] rise;
      logic [2:0] logged;
      rise = next_sev_status & ~sev_status;
      sev_status <= next_sev_status;
      cpu_event.nmi <= (|(rise & evt_map)) |
                       (system_instability_error & syserr_map);
      cpu_event.smi <= (|(rise & ~evt_map)) |
                       (system_instability_error & ~syserr_map);
      for (int c = 0; c < GEC_NUM_CLASSES; c++)
        logged[c] = |first_error_log[c];
      logged = logged & pin_en;
      error_pins.correctable_error_pin_n <= ~logged[GEC_CLS_CORR];
      error_pins.nonfatal_error_pin_n <= ~logged[GEC_CLS_NONFATAL];
      error_pins.fatal_error_pin_n <= ~logged[GEC_CLS_FATAL];
    end
  end

  // ==========================================================
  // APB read data, captured in the setup cycle
  // ==========================================================
  // Reading in setup keeps the bus answer free of wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      logic [1:0] k;
      logic [7:0] d;
      prdata <= '0;
      pslverr <= 1'b0;
      d = paddr - GEC_OFF_STAMP;
      k = class_of(paddr, GEC_OFF_STATUS);
      if (k != 2'b11)
        prdata[GEC_NUM_CLUSTERS-1:0] <= status[k];
      else if (class_of(paddr, GEC_OFF_GMASK) != 2'b11)
        prdata[GEC_NUM_CLUSTERS-1:0] <= gmask[class_of(paddr, GEC_OFF_GMASK)];
      else if (class_of(paddr, GEC_OFF_FIRST) != 2'b11)
        prdata[GEC_NUM_CLUSTERS-1:0] <=
          first_error_log[class_of(paddr, GEC_OFF_FIRST)];
      else if (class_of(paddr, GEC_OFF_NEXT) != 2'b11)
        prdata[GEC_NUM_CLUSTERS-1:0] <=
          next_error_log[class_of(paddr, GEC_OFF_NEXT)];
      else if (class_of(paddr, GEC_OFF_STAMP) != 2'b11)
        prdata[TS_WIDTH-1:0] <= stamp[d[3:2]];
      else if (paddr == GEC_OFF_SEV_STATUS)
        prdata[2:0] <= sev_status;
      else if (paddr == GEC_OFF_SEV_MASK)
        prdata[2:0] <= sev_mask;
      else if (paddr == GEC_OFF_EVT_MAP)
        prdata[2:0] <= evt_map;
      else if (paddr == GEC_OFF_PIN_EN)
        prdata[2:0] <= pin_en;
      else if (paddr == GEC_OFF_SYSERR_MAP)
        prdata[0] <= syserr_map;
      else if (paddr == GEC_OFF_TIMER)
        prdata[TS_WIDTH-1:0] <= timer;
      else
        pslverr <= 1'b1; // Unmapped address
    end
  end

endmodule : gec_global_error_collector

`default_nettype wire

// *** dv/gec_cluster_model.sv ***
// Local cluster model: one-cycle report pulses on request
`timescale 1ns/1ps
`default_nettype none
module gec_cluster_model
  import gec_pkg::*;
(
  input wire logic pclk,
  input wire logic fire,
  input wire gec_report_s pattern,
  input wire logic inst_fire,
  output gec_report_s err_report,
  output logic system_instability_error
);
  // One pulse per request, zero otherwise
  always @(posedge pclk)
  begin
    err_report <= fire ? pattern : '0;
    system_instability_error <= inst_fire;
  end
endmodule : gec_cluster_model
`default_nettype wire

// *** dv/gec_assertions.sv ***
// Port checker for the global error collector
`timescale 1ns/1ps
`default_nettype none
module gec_assertions
  import gec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire gec_report_s err_report,
  input wire logic system_instability_error,
  input wire logic platform_reset_out_n,
  input wire gec_event_s cpu_event,
  input wire gec_pins_s error_pins
);
  // Access decode and quiet-input helpers
  logic acc;
  logic wr;
  logic unmapped;
  logic quiet;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign unmapped = (paddr[3:0] == 4'hc && paddr < 8'h50) || paddr > 8'h64;
  assign quiet = !(|err_report) && !system_instability_error && !wr &&
    platform_reset_out_n;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  // ==========================================================
  a_pready_follow: assert property (pready == acc)
    else $error("pready does not follow the access phase");
  a_unmapped_err: assert property (acc && unmapped |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !unmapped && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_inst_event: assert property (system_instability_error |=>
    cpu_event != '0)
    else $error("instability error gave no event");
  a_no_spurious: assert property (quiet [*8] |=> cpu_event == '0)
    else $error("event without a cause");
  a_fatal_pin: assert property ($fell(error_pins.fatal_error_pin_n) |->
    $past(|err_report.fatal, 2) || $past(wr, 2))
    else $error("fatal pin fell without cause");
  a_corr_pin: assert property (
    $fell(error_pins.correctable_error_pin_n) |->
    $past(|err_report.correctable, 2) || $past(wr, 2))
    else $error("correctable pin fell without cause");
  a_reset_idle: assert property (disable iff (1'b0) !presetn |->
    error_pins == 3'h7 && cpu_event == '0)
    else $error("outputs not idle in reset");
endmodule : gec_assertions
bind gec_global_error_collector gec_assertions chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .err_report(err_report), .system_instability_error(system_instability_error),
  .platform_reset_out_n(platform_reset_out_n), .cpu_event(cpu_event),
  .error_pins(error_pins));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the global error collector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) \
  begin \
    total_checks++; \
    if ((g) !== (x)) \
    begin \
      num_errors++; \
      $display("wrong value %s expected %h seen %h", nm, x, g); \
    end \
  end
module testbench
  import gec_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic fire, inst_fire, sie, plt_n, pg;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq, t1;
  gec_report_s pattern, err_report;
  gec_event_s cpu_event;
  gec_pins_s error_pins;
  int num_errors = 0;
  int total_checks = 0;
  int nmi_cnt = 0;
  int smi_cnt = 0;
  int n0;
  gec_global_error_collector dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_report(err_report), .system_instability_error(sie),
    .platform_reset_out_n(plt_n), .core_power_good_in(pg),
    .cpu_event(cpu_event), .error_pins(error_pins));
  gec_cluster_model model_u (.pclk(pclk), .fire(fire), .pattern(pattern),
    .inst_fire(inst_fire), .err_report(err_report),
    .system_instability_error(sie));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Event pulse counters
  always @(posedge pclk)
  begin
    if (cpu_event.nmi === 1'b1) nmi_cnt++;
    if (cpu_event.smi === 1'b1) smi_cnt++;
  end
  // ==========================================================
  // Bus and stimulus tasks
  // ==========================================================
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] x,
                     input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, rq)
  endtask : chk
  task automatic pulse(input gec_report_s r, input logic inst);
    @(posedge pclk);
    pattern <= r;
    fire <= 1'b1;
    inst_fire <= inst;
    @(posedge pclk);
    fire <= 1'b0;
    inst_fire <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_defaults();
    chk(8'h58, 32'h6, "event map");
    chk(8'h54, 32'h0, "severity mask");
    chk(8'h14, 32'h0, "global mask");
    chk(8'h60, 32'h1, "instability map");
    chk(8'h08, 32'h0, "fatal status");
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped error", 1'b1, re)
  endtask : t_defaults
  task automatic t_fatal();
    apb(1'b1, 8'h5c, 32'h4);
    n0 = nmi_cnt;
    apb(1'b0, 8'h64, 32'h0);
    t1 = rq;
    pulse({7'h01, 14'h0}, 1'b0);
    chk(8'h08, 32'h1, "fatal status");
    chk(8'h28, 32'h1, "fatal first");
    `CHK("fatal pin", 1'b0, error_pins.fatal_error_pin_n)
    `CHK("nmi count", n0 + 1, nmi_cnt)
    apb(1'b0, 8'h48, 32'h0);
    `CHK("stamp window", 1'b1, rq > t1 && rq - t1 < 32'h20)
    pulse({7'h01, 14'h0}, 1'b0);
    chk(8'h38, 32'h0, "next after repeat");
    pulse({7'h08, 14'h0}, 1'b0);
    chk(8'h38, 32'h8, "fatal next");
    chk(8'h28, 32'h1, "fatal first kept");
  endtask : t_fatal
  task automatic t_clear();
    apb(1'b1, 8'h08, 32'h0);
    chk(8'h08, 32'h9, "status write zero");
    apb(1'b1, 8'h08, 32'h1);
    chk(8'h08, 32'h8, "status write one");
    apb(1'b1, 8'h28, 32'h1);
    chk(8'h28, 32'h0, "first cleared");
    chk(8'h38, 32'h0, "next dropped");
    `CHK("fatal pin off", 1'b1, error_pins.fatal_error_pin_n)
  endtask : t_clear
  task automatic t_same_cycle();
    n0 = smi_cnt;
    apb(1'b1, 8'h5c, 32'h7);
    pulse({14'h0, 7'h26}, 1'b0);
    chk(8'h20, 32'h2, "corr first");
    chk(8'h30, 32'h4, "corr next");
    chk(8'h00, 32'h26, "corr status");
    `CHK("smi count", n0 + 1, smi_cnt)
    `CHK("corr pin", 1'b0, error_pins.correctable_error_pin_n)
  endtask : t_same_cycle
  task automatic t_masks();
    apb(1'b1, 8'h14, 32'h1);
    pulse({7'h0, 7'h01, 7'h0}, 1'b0);
    chk(8'h04, 32'h0, "masked status");
    pulse({7'h0, 7'h02, 7'h0}, 1'b0);
    chk(8'h04, 32'h2, "unmasked status");
    chk(8'h50, 32'h7, "severity status");
    `CHK("nonfatal pin", 1'b0, error_pins.nonfatal_error_pin_n)
    apb(1'b1, 8'h54, 32'h2);
    chk(8'h50, 32'h5, "severity masked");
    plt_n <= 1'b0;
    repeat (10) @(posedge pclk);
    plt_n <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(8'h14, 32'h0, "global mask reset");
    chk(8'h54, 32'h0, "severity mask reset");
    chk(8'h20, 32'h2, "log kept");
    pg <= 1'b0;
    repeat (10) @(posedge pclk);
    pg <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(8'h20, 32'h0, "log lost");
    `CHK("corr pin off", 1'b1, error_pins.correctable_error_pin_n)
    chk(8'h00, 32'h26, "status kept");
  endtask : t_masks
  task automatic t_instability();
    n0 = nmi_cnt;
    pulse('0, 1'b1);
    `CHK("instability nmi", n0 + 1, nmi_cnt)
    n0 = smi_cnt;
    apb(1'b1, 8'h60, 32'h0);
    pulse('0, 1'b1);
    `CHK("instability smi", n0 + 1, smi_cnt)
  endtask : t_instability
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, fire, inst_fire} = '0;
    {plt_n, pg, presetn} = 3'h7;
    paddr = 8'h0;
    pwdata = 32'h0;
    pattern = '0;
    // Fall after time zero so every reset branch sees the edge
    #1 presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_fatal();
    t_clear();
    t_same_cycle();
    t_masks();
    t_instability();
    test_done();
  end
endmodule : testbench
`default_nettype wire
